// File: core/fan_speed_control.sv
// Two-fan tach measurement, drive generation and automatic loops
//
// Function
// - Tach counts of both fans readable at indexes 28h and 29h.
// - Count ticks scaled so rpm equals 1.35e6 over count times divisor.
// - Divisor codes from 47h bits 7-4 and 5Dh bits 6-5, default two.
// - Three-bit divisor code n selects divide by two to the n.
// - Two drive outputs; 04h bits 1-0 pick PWM or DC each.
// - PWM duty equals output value register over 255.
// - Both output value registers reset to FFh, full duty.
// - Carrier rate of each output set by sys_fan_pwm_clock or 02h.
// - DC type drives six-bit code, supply times code over 64.
// - DC level in upper six bits, default ones, low two reserved.
// - Automatic loops start from the value already held.
// - Each fan follows temperature source chosen by 4Ah or 49h.
// - Fan off below low end; starts at start-up value above it.
// - Above high end output rises; full scale and hot raises warning.
// - Inside the window the output holds.
// - Below low end fall to zero or enabled stop value.
// - Stop value held for stop time of 0Ch or 0Dh.
// - Speed loop raises output on high count, lowers on low count.
//
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module fan_speed_control #(
  parameter int STEP_UNIT_CYCLES = fan_pkg::STEP_UNIT_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input fan_pkg::apb_req_type apb_req,
  output fan_pkg::apb_rsp_type apb_rsp,
  input wire logic [7:0] system_temp_input,
  input wire logic [7:0] processor_temp_input,
  input wire logic system_fan_tach,
  input wire logic processor_fan_tach,
  output logic system_fan_drive,
  output logic processor_fan_drive,
  output logic [5:0] system_fan_dc_level,
  output logic [5:0] processor_fan_dc_level,
  output logic fan_full_warning
);
  fan_pkg::core_state_type s;
  fan_pkg::core_state_type n;
  logic [1:0][7:0] tach;
  logic [1:0] tach_pin;
  logic [1:0] drive;
  logic [1:0][5:0] dc_level;
  logic [1:0][2:0] div_code;
  logic [6:0] idx;
  logic mapped;
  logic [8:0] rd;
  logic wr_en;

  // ===================================================
  // Helpers
  function automatic logic [7:0] sat_inc(input logic [7:0] v);
    sat_inc = (v == 8'hff) ? v : v + 8'h01;
  endfunction

  function automatic logic [7:0] sat_dec(input logic [7:0] v);
    sat_dec = (v == 8'h00) ? v : v - 8'h01;
  endfunction

  // Window ends clamp rather than wrap
  function automatic logic [7:0] win_low(
    input logic [7:0] t,
    input logic [3:0] tol
  );
    win_low = (t > {4'h0, tol}) ? t - {4'h0, tol} : 8'h00;
  endfunction

  function automatic logic [7:0] win_high(
    input logic [7:0] t,
    input logic [3:0] tol
  );
    logic [8:0] sum;
    sum = {1'b0, t} + {5'h00, tol};
    win_high = sum[8] ? 8'hff : sum[7:0];
  endfunction

  // Source code zero is the system sensor, any other the processor
  function automatic logic [7:0] pick_temp(
    input logic [2:0] code,
    input logic [7:0] sys_t,
    input logic [7:0] cpu_t
  );
    pick_temp = (code == 3'h0) ? sys_t : cpu_t;
  endfunction

  // Read decode: hit flag and data
  function automatic logic [8:0] read_reg(
    input fan_pkg::core_state_type st,
    input logic [6:0] i,
    input logic [1:0][7:0] tc
  );
    case (i)
      fan_pkg::IDX_SYS_PWM_CLOCK: read_reg = {1'b1, st.pwm_clock[0]};
      fan_pkg::IDX_SYS_OUT_VALUE: read_reg = {1'b1, st.out_value[0]};
      fan_pkg::IDX_CPU_PWM_CLOCK: read_reg = {1'b1, st.pwm_clock[1]};
      fan_pkg::IDX_CPU_OUT_VALUE: read_reg = {1'b1, st.out_value[1]};
      fan_pkg::IDX_TYPE_SELECT: read_reg = {1'b1, st.type_sel};
      fan_pkg::IDX_SYS_TARGET: read_reg = {1'b1, st.target[0]};
      fan_pkg::IDX_CPU_TARGET: read_reg = {1'b1, st.target[1]};
      fan_pkg::IDX_TOLERANCE: read_reg = {1'b1, st.tolerance};
      fan_pkg::IDX_SYS_STOP_VALUE: read_reg = {1'b1, st.stop_value[0]};
      fan_pkg::IDX_CPU_STOP_VALUE: read_reg = {1'b1, st.stop_value[1]};
      fan_pkg::IDX_SYS_STARTUP: read_reg = {1'b1, st.startup[0]};
      fan_pkg::IDX_CPU_STARTUP: read_reg = {1'b1, st.startup[1]};
      fan_pkg::IDX_SYS_STOP_TIME: read_reg = {1'b1, st.stop_time[0]};
      fan_pkg::IDX_CPU_STOP_TIME: read_reg = {1'b1, st.stop_time[1]};
      fan_pkg::IDX_STEP_DOWN: read_reg = {1'b1, st.step_down};
      fan_pkg::IDX_STEP_UP: read_reg = {1'b1, st.step_up};
      fan_pkg::IDX_STOP_ENABLES: read_reg = {1'b1, st.stop_en};
      fan_pkg::IDX_TACH_COUNT_A: read_reg = {1'b1, tc[0]};
      fan_pkg::IDX_TACH_COUNT_B: read_reg = {1'b1, tc[1]};
      fan_pkg::IDX_DIVISOR_LOW: read_reg = {1'b1, st.div_low};
      fan_pkg::IDX_CPU_TEMP_SRC: read_reg = {1'b1, st.cpu_src};
      fan_pkg::IDX_SYS_TEMP_SRC: read_reg = {1'b1, st.sys_src};
      fan_pkg::IDX_DIVISOR_HIGH: read_reg = {1'b1, st.div_high};
      fan_pkg::IDX_LOOP_MODE: read_reg = {1'b1, 4'h0, st.mode};
      fan_pkg::IDX_LOOP_STATUS: read_reg = {1'b1, 6'h00, st.warn};
      default: read_reg = 9'h000;
    endcase
  endfunction

  // ===================================================
  // Bus decode
  assign idx = apb_req.paddr[8:2];
  assign mapped = (apb_req.paddr[1:0] == 2'h0)
                  && (apb_req.paddr[11:9] == 3'h0);
  assign rd = read_reg(s, idx, tach);
  // Zero wait states, so every access phase completes
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite
                 && mapped && rd[8];

  // ===================================================
  // Next state: bus, loops and writes
  always_comb begin
    logic [7:0] temp;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] floor_v;
    logic [7:0] out;
    logic [7:0] w;
    logic [1:0] mode;
    logic [1:0] warn_set;
    logic [1:0] warn_clr;
    logic tick;
    logic up_ok;
    logic dn_ok;
    logic stop_on;
    temp = 8'h00;
    lo = 8'h00;
    hi = 8'h00;
    floor_v = 8'h00;
    out = 8'h00;
    w = apb_req.pwdata[7:0];
    mode = fan_pkg::MODE_MANUAL;
    warn_set = 2'b00;
    warn_clr = 2'b00;
    up_ok = 1'b0;
    dn_ok = 1'b0;
    stop_on = 1'b0;
    tick = 1'b0;
    n = s;
    // Read data and error captured in the setup cycle
    if (apb_req.psel && !apb_req.penable) begin
      n.prdata = (mapped && rd[8]) ? rd[7:0] : 8'h00;
      n.err = !(mapped && rd[8]);
    end
    // Step unit divider
    tick = s.unit_cnt == 32'(STEP_UNIT_CYCLES - 1);
    n.unit_cnt = tick ? 32'h0 : s.unit_cnt + 32'h1;
    for (int f = 0; f < 2; f++) begin
      mode = s.mode[2 * f +: 2];
      temp = (f == 0)
        ? pick_temp(s.sys_src[fan_pkg::SYS_SRC_LSB +: 3],
                    system_temp_input, processor_temp_input)
        : pick_temp(s.cpu_src[fan_pkg::CPU_SRC_LSB +: 3],
                    system_temp_input, processor_temp_input);
      lo = win_low(s.target[f], s.tolerance[4 * f +: 4]);
      hi = win_high(s.target[f], s.tolerance[4 * f +: 4]);
      stop_on = s.stop_en[fan_pkg::STOP_EN_SYS_BIT - f];
      floor_v = stop_on ? s.stop_value[f] : 8'h00;
      // loops work on the value already held
      out = s.out_value[f];
      up_ok = s.step_timer[f] >= s.step_up;
      dn_ok = s.step_timer[f] >= s.step_down;
      if (mode == fan_pkg::MODE_MANUAL) begin
        n.loop_state[f] = fan_pkg::ST_RUN;
        n.step_timer[f] = 8'h00;
        n.hold_timer[f] = 8'h00;
      end else if (tick) begin
        n.step_timer[f] = sat_inc(s.step_timer[f]);
        if (mode == fan_pkg::MODE_SPEED) begin
          // count above window speeds up, below slows
          if (tach[f] > hi && up_ok) begin
            out = sat_inc(out);
            n.step_timer[f] = 8'h00;
          end else if (tach[f] < lo && dn_ok) begin
            out = sat_dec(out);
            n.step_timer[f] = 8'h00;
          end
        end else begin
          case (s.loop_state[f])
            fan_pkg::ST_OFF: begin
              // off until above the low end
              if (temp > lo) begin
                out = s.startup[f];
                n.loop_state[f] = fan_pkg::ST_RUN;
              end else begin
                out = 8'h00;
              end
            end
            fan_pkg::ST_RUN: begin
              if (temp > hi) begin
                // ramp up, warn at full scale
                if (out == 8'hff) begin
                  warn_set[f] = 1'b1;
                end else if (up_ok) begin
                  out = sat_inc(out);
                  n.step_timer[f] = 8'h00;
                end
              end else if (temp < lo) begin
                // ramp down to zero or stop value
                if (out <= floor_v) begin
                  out = floor_v;
                  if (stop_on) begin
                    n.hold_timer[f] = s.stop_time[f];
                    n.loop_state[f] = fan_pkg::ST_HOLD;
                  end else begin
                    n.loop_state[f] = fan_pkg::ST_OFF;
                  end
                end else if (dn_ok) begin
                  out = sat_dec(out);
                  n.step_timer[f] = 8'h00;
                end
              end
            end
            fan_pkg::ST_HOLD: begin
              // stay at stop value for the stop time
              if (temp > lo) begin
                n.loop_state[f] = fan_pkg::ST_RUN;
              end else if (s.hold_timer[f] == 8'h00) begin
                out = 8'h00;
                n.loop_state[f] = fan_pkg::ST_OFF;
              end else begin
                n.hold_timer[f] = s.hold_timer[f] - 8'h01;
              end
            end
            default: begin
              n.loop_state[f] = fan_pkg::ST_RUN;
            end
          endcase
        end
      end
      n.out_value[f] = out;
    end
    // Software writes; an output value write beats the loop
    if (wr_en) begin
      case (idx)
        fan_pkg::IDX_SYS_PWM_CLOCK: n.pwm_clock[0] = w;
        fan_pkg::IDX_SYS_OUT_VALUE: n.out_value[0] = w;
        fan_pkg::IDX_CPU_PWM_CLOCK: n.pwm_clock[1] = w;
        fan_pkg::IDX_CPU_OUT_VALUE: n.out_value[1] = w;
        fan_pkg::IDX_TYPE_SELECT: n.type_sel = w;
        fan_pkg::IDX_SYS_TARGET: n.target[0] = w;
        fan_pkg::IDX_CPU_TARGET: n.target[1] = w;
        fan_pkg::IDX_TOLERANCE: n.tolerance = w;
        fan_pkg::IDX_SYS_STOP_VALUE: n.stop_value[0] = w;
        fan_pkg::IDX_CPU_STOP_VALUE: n.stop_value[1] = w;
        fan_pkg::IDX_SYS_STARTUP: n.startup[0] = w;
        fan_pkg::IDX_CPU_STARTUP: n.startup[1] = w;
        fan_pkg::IDX_SYS_STOP_TIME: n.stop_time[0] = w;
        fan_pkg::IDX_CPU_STOP_TIME: n.stop_time[1] = w;
        fan_pkg::IDX_STEP_DOWN: n.step_down = w;
        fan_pkg::IDX_STEP_UP: n.step_up = w;
        fan_pkg::IDX_STOP_ENABLES: n.stop_en = w;
        fan_pkg::IDX_DIVISOR_LOW: n.div_low = w;
        fan_pkg::IDX_CPU_TEMP_SRC: n.cpu_src = w;
        fan_pkg::IDX_SYS_TEMP_SRC: n.sys_src = w;
        fan_pkg::IDX_DIVISOR_HIGH: n.div_high = w;
        fan_pkg::IDX_LOOP_MODE: n.mode = w[3:0];
        fan_pkg::IDX_LOOP_STATUS: warn_clr = w[1:0];
        default: begin
        end
      endcase
    end
    // Write-one clears; a warning in the same cycle survives
    n.warn = (s.warn & ~warn_clr) | warn_set;
  end

  // ===================================================
  // State register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      s.out_value <= {2{fan_pkg::RST_OUT_VALUE}};
      s.div_low <= fan_pkg::RST_DIVISOR_LOW;
      s.cpu_src <= fan_pkg::RST_CPU_TEMP_SRC;
      s.step_up <= fan_pkg::RST_STEP_TIME;
      s.step_down <= fan_pkg::RST_STEP_TIME;
      s.loop_state[0] <= fan_pkg::ST_RUN;
      s.loop_state[1] <= fan_pkg::ST_RUN;
    end else begin
      s <= n;
    end
  end

  // ===================================================
  // Channels
  assign tach_pin = {processor_fan_tach, system_fan_tach};
  assign div_code[0] = {s.div_high[fan_pkg::DIV_HIGH_LSB],
                        s.div_low[fan_pkg::DIV_LOW_LSB +: 2]};
  assign div_code[1] = {s.div_high[fan_pkg::DIV_HIGH_LSB + 1],
                        s.div_low[fan_pkg::DIV_LOW_LSB + 2 +: 2]};

  for (genvar g = 0; g < 2; g++) begin : gen_ch
    // type bit per output, set means DC
    fan_channel u_ch (
      .clk(clk),
      .arst_n(arst_n),
      .tach_pin(tach_pin[g]),
      .div_code(div_code[g]),
      .pwm_clock(s.pwm_clock[g]),
      .value(s.out_value[g]),
      .dc_mode(s.type_sel[g]),
      .drive(drive[g]),
      .dc_level(dc_level[g]),
      .tach_count(tach[g])
    );
  end

  // Outputs
  assign system_fan_drive = drive[0];
  assign processor_fan_drive = drive[1];
  assign system_fan_dc_level = dc_level[0];
  assign processor_fan_dc_level = dc_level[1];
  assign fan_full_warning = |s.warn;
  assign apb_rsp.prdata = {24'h000000, s.prdata};
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = s.err && apb_req.psel && apb_req.penable;
endmodule

// File: inc/fan_pkg.sv
// Constants, register map and state types for the fan control block
package fan_pkg;
  // ===================================================
  // Timing
  localparam int CLK_HZ = 40_000_000;
  // Tach sample rate: 1.35e6 counts per minute
  localparam int TACH_RATE_HZ = 22_500;
  localparam logic [10:0] TACH_TICK_CYCLES =
    11'((CLK_HZ + TACH_RATE_HZ / 2) / TACH_RATE_HZ);
  // Loop step unit and stop time unit
  localparam int STEP_UNIT_MS = 100;
  localparam int STEP_UNIT_CYCLES = CLK_HZ / 1000 * STEP_UNIT_MS;
  // Last PWM step; 255 steps per period
  localparam logic [7:0] PWM_LAST = 8'hfe;
  // ===================================================
  // Register indexes (byte address is four times the index)
  localparam logic [6:0] IDX_SYS_PWM_CLOCK = 7'h00;
  localparam logic [6:0] IDX_SYS_OUT_VALUE = 7'h01;
  localparam logic [6:0] IDX_CPU_PWM_CLOCK = 7'h02;
  localparam logic [6:0] IDX_CPU_OUT_VALUE = 7'h03;
  localparam logic [6:0] IDX_TYPE_SELECT = 7'h04;
  localparam logic [6:0] IDX_SYS_TARGET = 7'h05;
  localparam logic [6:0] IDX_CPU_TARGET = 7'h06;
  localparam logic [6:0] IDX_TOLERANCE = 7'h07;
  localparam logic [6:0] IDX_SYS_STOP_VALUE = 7'h08;
  localparam logic [6:0] IDX_CPU_STOP_VALUE = 7'h09;
  localparam logic [6:0] IDX_SYS_STARTUP = 7'h0a;
  localparam logic [6:0] IDX_CPU_STARTUP = 7'h0b;
  localparam logic [6:0] IDX_SYS_STOP_TIME = 7'h0c;
  localparam logic [6:0] IDX_CPU_STOP_TIME = 7'h0d;
  localparam logic [6:0] IDX_STEP_DOWN = 7'h0e;
  localparam logic [6:0] IDX_STEP_UP = 7'h0f;
  localparam logic [6:0] IDX_STOP_ENABLES = 7'h12;
  localparam logic [6:0] IDX_TACH_COUNT_A = 7'h28;
  localparam logic [6:0] IDX_TACH_COUNT_B = 7'h29;
  localparam logic [6:0] IDX_DIVISOR_LOW = 7'h47;
  localparam logic [6:0] IDX_CPU_TEMP_SRC = 7'h49;
  localparam logic [6:0] IDX_SYS_TEMP_SRC = 7'h4a;
  localparam logic [6:0] IDX_DIVISOR_HIGH = 7'h5d;
  localparam logic [6:0] IDX_LOOP_MODE = 7'h60;
  localparam logic [6:0] IDX_LOOP_STATUS = 7'h61;
  // ===================================================
  // Reset values
  localparam logic [7:0] RST_OUT_VALUE = 8'hff;
  localparam logic [7:0] RST_DIVISOR_LOW = 8'h50;
  localparam logic [7:0] RST_CPU_TEMP_SRC = 8'h01;
  localparam logic [7:0] RST_STEP_TIME = 8'h01;
  localparam logic [7:0] RST_TACH_COUNT = 8'hff;
  // ===================================================
  // Field positions
  localparam int DIV_LOW_LSB = 4;
  localparam int DIV_HIGH_LSB = 5;
  localparam int STOP_EN_SYS_BIT = 5;
  localparam int SYS_SRC_LSB = 5;
  localparam int CPU_SRC_LSB = 0;
  localparam logic [1:0] MODE_MANUAL = 2'b00;
  localparam logic [1:0] MODE_THERMAL = 2'b01;
  localparam logic [1:0] MODE_SPEED = 2'b10;
  // ===================================================
  // Types
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_HOLD = 3'b100
  } loop_state_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;
  typedef struct packed {
    logic [1:0] sync;
    logic tach_prev;
    logic [10:0] tick_cnt;
    logic [6:0] prescale;
    logic [7:0] run_cnt;
    logic [7:0] count;
    logic [7:0] pwm_div;
    logic [7:0] pwm_cnt;
    logic [7:0] duty;
    logic drive;
    logic [5:0] dc_level;
  } channel_state_type;
  typedef struct packed {
    logic [1:0][7:0] pwm_clock;
    logic [1:0][7:0] out_value;
    logic [1:0][7:0] target;
    logic [1:0][7:0] stop_value;
    logic [1:0][7:0] startup;
    logic [1:0][7:0] stop_time;
    logic [7:0] type_sel;
    logic [7:0] tolerance;
    logic [7:0] step_down;
    logic [7:0] step_up;
    logic [7:0] stop_en;
    logic [7:0] div_low;
    logic [7:0] div_high;
    logic [7:0] cpu_src;
    logic [7:0] sys_src;
    logic [3:0] mode;
    logic [1:0] warn;
    loop_state_type [1:0] loop_state;
    logic [1:0][7:0] step_timer;
    logic [1:0][7:0] hold_timer;
    logic [31:0] unit_cnt;
    logic [7:0] prdata;
    logic err;
  } core_state_type;
endpackage

// File: core/fan_channel.sv
// One fan channel: tach period counter and PWM / DC drive generator
`timescale 1ns/1ps
module fan_channel (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic tach_pin,
  input wire logic [2:0] div_code,
  input wire logic [7:0] pwm_clock,
  input wire logic [7:0] value,
  input wire logic dc_mode,
  output logic drive,
  output logic [5:0] dc_level,
  output logic [7:0] tach_count
);
  fan_pkg::channel_state_type s;
  fan_pkg::channel_state_type n;
  logic rate_tick;
  logic count_tick;
  logic pwm_step;

  // Prescale mask for a divide ratio of two to the power code
  function automatic logic [6:0] div_mask(input logic [2:0] code);
    div_mask = 7'((8'h01 << code) - 8'h01);
  endfunction

  // ===================================================
  // Next state
  always_comb begin
    n = s;
    // Two-stage synchroniser on the tach pin
    n.sync = {s.sync[0], tach_pin};
    n.tach_prev = s.sync[1];
    rate_tick = s.tick_cnt == fan_pkg::TACH_TICK_CYCLES - 11'h001;
    n.tick_cnt = rate_tick ? 11'h000 : s.tick_cnt + 11'h001;
    count_tick = rate_tick && (s.prescale >= div_mask(div_code));
    if (rate_tick) begin
      n.prescale = count_tick ? 7'h00 : s.prescale + 7'h01;
    end
    // count divided ticks between rising tach edges
    if (s.sync[1] && !s.tach_prev) begin
      n.count = s.run_cnt;
      // A tick on the edge cycle goes to the new period, never lost
      n.run_cnt = count_tick ? 8'h01 : 8'h00;
    end else if (count_tick) begin
      if (s.run_cnt == 8'hff) begin
        n.count = 8'hff;
      end else begin
        n.run_cnt = s.run_cnt + 8'h01;
      end
    end
    // carrier rate set by the clock register
    pwm_step = s.pwm_div >= pwm_clock;
    n.pwm_div = pwm_step ? 8'h00 : s.pwm_div + 8'h01;
    if (pwm_step) begin
      if (s.pwm_cnt == fan_pkg::PWM_LAST) begin
        n.pwm_cnt = 8'h00;
        // new value only at a period edge
        n.duty = value;
      end else begin
        n.pwm_cnt = s.pwm_cnt + 8'h01;
      end
    end
    n.drive = !dc_mode && (n.pwm_cnt < n.duty);
    // six-bit converter code, low bits ignored
    n.dc_level = dc_mode ? n.duty[7:2] : 6'h00;
  end

  // State register; duty starts full
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= '0;
      // Idle tach line is pulled high; no false edge after reset
      s.sync <= 2'b11;
      s.tach_prev <= 1'b1;
      s.count <= fan_pkg::RST_TACH_COUNT;
      s.duty <= fan_pkg::RST_OUT_VALUE;
      s.drive <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign drive = s.drive;
  assign dc_level = s.dc_level;
  assign tach_count = s.count;
endmodule

// File: bench/fan_properties.sv
// Bus and drive output checks for the fan control block
`timescale 1ns/1ps
module fan_properties #(
  parameter int STEP_UNIT_CYCLES = 20
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire fan_pkg::apb_req_type apb_req,
  input wire fan_pkg::apb_rsp_type apb_rsp,
  input wire logic system_fan_drive,
  input wire logic processor_fan_drive,
  input wire logic [5:0] system_fan_dc_level,
  input wire logic [5:0] processor_fan_dc_level,
  input wire logic fan_full_warning
);
  // ==============================================
  // Clocking and sequences
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_setup;
    apb_req.psel && !apb_req.penable;
  endsequence
  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence
  // ==============================================
  // Properties
  property p_ready;
    s_access |-> apb_rsp.pready;
  endproperty
  property p_err_phase;
    apb_rsp.pslverr |-> apb_req.psel && apb_req.penable;
  endproperty
  property p_err_data;
    apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0;
  endproperty
  property p_upper;
    s_access |-> apb_rsp.prdata[31:8] == 24'h0;
  endproperty
  // Misaligned or out of range address is refused
  property p_bad_addr;
    apb_req.psel && !apb_req.penable && (apb_req.paddr[1:0] != 2'h0 ||
      apb_req.paddr[11:9] != 3'h0) ##1 s_access |-> apb_rsp.pslverr;
  endproperty
  // Read data holds in the idle cycle after an access
  property p_hold;
    s_access ##1 !apb_req.psel |-> $stable(apb_rsp.prdata);
  endproperty
  property p_dc_sys;
    system_fan_dc_level != 6'h0 |-> !system_fan_drive;
  endproperty
  property p_dc_cpu;
    processor_fan_dc_level != 6'h0 |-> !processor_fan_drive;
  endproperty
  // Full duty, no level and no warning after reset
  property p_reset;
    $rose(arst_n) |-> (system_fan_drive && processor_fan_drive &&
      system_fan_dc_level == 6'h0 && processor_fan_dc_level == 6'h0 &&
      !fan_full_warning) [*8];
  endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  a_err_phase: assert property (p_err_phase) else $error("err out of phase");
  a_err_data: assert property (p_err_data) else $error("err with data");
  a_upper: assert property (p_upper) else $error("upper read bits set");
  a_bad_addr: assert property (p_bad_addr) else $error("bad address taken");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_dc_sys: assert property (p_dc_sys) else $error("fan A both types");
  a_dc_cpu: assert property (p_dc_cpu) else $error("fan B both types");
  a_reset: assert property (p_reset) else $error("bad reset outputs");
endmodule
bind fan_speed_control fan_properties #(
  .STEP_UNIT_CYCLES(STEP_UNIT_CYCLES)
) i_fan_properties (.clk, .arst_n, .apb_req, .apb_rsp,
  .system_fan_drive, .processor_fan_drive, .system_fan_dc_level,
  .processor_fan_dc_level, .fan_full_warning);

// File: bench/fan_model.sv
// Two fans whose tach lines pulse at a set half period
`timescale 1ns/1ps
module fan_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [15:0] half_a,
  input wire logic [15:0] half_b,
  output logic tach_a,
  output logic tach_b
);
  logic [15:0] ca;
  logic [15:0] cb;
  // Half period zero is a stalled fan: pull-up holds the line high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ca <= 16'h0;
      cb <= 16'h0;
      tach_a <= 1'b1;
      tach_b <= 1'b1;
    end else begin
      ca <= (half_a == 16'h0 || ca >= half_a - 16'h1) ? 16'h0 : ca + 16'h1;
      cb <= (half_b == 16'h0 || cb >= half_b - 16'h1) ? 16'h0 : cb + 16'h1;
      tach_a <= (half_a == 16'h0) ? 1'b1 :
        (ca >= half_a - 16'h1) ? ~tach_a : tach_a;
      tach_b <= (half_b == 16'h0) ? 1'b1 :
        (cb >= half_b - 16'h1) ? ~tach_b : tach_b;
    end
  end
endmodule

// File: bench/test_fan_speed_control.sv
// Register bus driven bench for the fan control block
`timescale 1ns/1ps
module test_fan_speed_control;
  logic clk;
  logic arst_n;
  fan_pkg::apb_req_type req;
  fan_pkg::apb_rsp_type rsp;
  logic [7:0] st_t;
  logic [7:0] ct_t;
  logic ta;
  logic tb;
  logic [15:0] ha;
  logic [15:0] hb;
  logic sd;
  logic cd;
  logic [5:0] sl;
  logic [5:0] cl;
  logic warn;
  int bad_count;
  int tests_run;
  logic [31:0] q;
  logic e;
  int na;
  int nb;
  // ==============================================
  // Design and fans
  fan_speed_control #(.STEP_UNIT_CYCLES(20)) i_fan_speed_control (
    .clk(clk), .arst_n(arst_n), .apb_req(req), .apb_rsp(rsp),
    .system_temp_input(st_t), .processor_temp_input(ct_t),
    .system_fan_tach(ta), .processor_fan_tach(tb),
    .system_fan_drive(sd), .processor_fan_drive(cd),
    .system_fan_dc_level(sl), .processor_fan_dc_level(cl),
    .fan_full_warning(warn));
  fan_model i_fan_model (.clk(clk), .arst_n(arst_n), .half_a(ha),
    .half_b(hb), .tach_a(ta), .tach_b(tb));
  // 25 ns clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==============================================
  // Tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  // One transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= {24'h0, d};
    @(posedge clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      stop_test();
    end
    q = rsp.prdata;
    e = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    apb(1'b1, {3'h0, i, 2'h0}, d);
  endtask
  task automatic rd(input logic [6:0] i, input logic [7:0] x);
    apb(1'b0, {3'h0, i, 2'h0}, 8'h0);
    chk({31'h0, e}, 32'h0);
    chk(q, {24'h0, x});
  endtask
  // ==============================================
  // Main sequence
  initial begin
    static logic [6:0] rw [10] = '{7'h00, 7'h02, 7'h08, 7'h09, 7'h0c, 7'h0d,
      7'h12, 7'h49, 7'h4a, 7'h5d};
    req = '0;
    st_t = 8'h0;
    ct_t = 8'h0;
    ha = 16'h0;
    hb = 16'h0;
    bad_count = 0;
    tests_run = 0;
    arst_n = 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    rd(7'h01, 8'hff);
    rd(7'h03, 8'hff);
    rd(7'h47, 8'h50);
    wr(7'h28, 8'h00);
    rd(7'h28, 8'hff);
    foreach (rw[k]) wr(rw[k], 8'h5a);
    foreach (rw[k]) rd(rw[k], 8'h5a);
    foreach (rw[k]) wr(rw[k], 8'h00);
    apb(1'b0, 12'h1fc, 8'h0);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h006, 8'h1);
    chk({31'h0, e}, 32'h1);
    $display("registers done");
    wr(7'h02, 8'h01);
    wr(7'h01, 8'h40);
    wr(7'h03, 8'h80);
    repeat (1100) @(posedge clk);
    na = 0;
    nb = 0;
    repeat (510) begin
      @(posedge clk);
      if (sd === 1'b1) na++;
      if (cd === 1'b1) nb++;
    end
    chk(na, 128);
    chk(nb, 256);
    $display("pwm done");
    wr(7'h04, 8'h03);
    wr(7'h01, 8'hab);
    repeat (600) @(posedge clk);
    chk({18'h0, sd, cd, sl, cl}, {18'h0, 2'b00, 6'h2a, 6'h20});
    $display("dc done");
    wr(7'h47, 8'h40);
    ha <= 16'd7112;
    hb <= 16'd7112;
    repeat (45000) @(posedge clk);
    rd(7'h28, 8'h08);
    rd(7'h29, 8'h04);
    $display("tach done");
    wr(7'h05, 8'h32);
    wr(7'h07, 8'h03);
    wr(7'h0a, 8'h33);
    wr(7'h01, 8'h80);
    st_t <= 8'd50;
    wr(7'h60, 8'h01);
    repeat (200) @(posedge clk);
    rd(7'h01, 8'h80);
    st_t <= 8'd60;
    repeat (200) @(posedge clk);
    apb(1'b0, 12'h004, 8'h0);
    chk({31'h0, q[7:0] > 8'h80}, 32'h1);
    st_t <= 8'd40;
    repeat (8000) @(posedge clk);
    rd(7'h01, 8'h00);
    st_t <= 8'd48;
    repeat (200) @(posedge clk);
    rd(7'h01, 8'h33);
    st_t <= 8'd60;
    wr(7'h01, 8'hff);
    repeat (100) @(posedge clk);
    chk({31'h0, warn}, 32'h1);
    rd(7'h61, 8'h01);
    wr(7'h60, 8'h00);
    wr(7'h61, 8'h01);
    rd(7'h61, 8'h00);
    wr(7'h01, 8'h21);
    wr(7'h12, 8'h20);
    wr(7'h08, 8'h20);
    wr(7'h0c, 8'h05);
    st_t <= 8'd40;
    wr(7'h60, 8'h01);
    repeat (100) @(posedge clk);
    rd(7'h01, 8'h20);
    repeat (200) @(posedge clk);
    rd(7'h01, 8'h00);
    wr(7'h60, 8'h02);
    wr(7'h05, 8'h04);
    repeat (200) @(posedge clk);
    apb(1'b0, 12'h004, 8'h0);
    chk({31'h0, q[7:0] > 8'h00}, 32'h1);
    $display("thermal done");
    stop_test();
  end
endmodule
